/* File: aux_clock_and_lock_detect.sv */
// Auxiliary clock generator, delay modulator and lock detector with register file
`timescale 1ns/1ps
module aux_clock_and_lock_detect
  import aux_clock_pkg::*;
#(
  parameter int RING_HALF_BASE = 2,
  parameter int WIN_BASE = 1024,
  parameter int DELAY_TAPS = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  input wire logic vco_div_clk_i,
  input wire logic xref_clk_i,
  input wire logic ref_div_clk_i,
  input wire logic natural_ref_clk_i,
  input wire logic ref_clk_i,
  input wire logic analog_window_i,
  input wire logic sdo_read_active_i,
  input wire logic sdo_read_data_i,
  output logic serial_data_o,
  output logic aux_clk_o,
  output logic dsm_ref_clk_o,
  output logic [2:0] delay_setting_o,
  output logic ring_osc_o,
  output logic lock_window_o,
  output logic locked_o
);

  // Edge test used on every sampled clock except natural_ref_clk_i, which is only retimed
  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  aux_cfg_one_type cfg_one_r;
  aux_cfg_two_type cfg_two_r;
  lock_cfg_type lock_cfg_r;
  logic locked_r;
  logic [23:0] rdata_nxt;

  wire wr_one = reg_wr_i && (reg_addr_i == ADDR_AUX_CFG_ONE);
  wire wr_two = reg_wr_i && (reg_addr_i == ADDR_AUX_CFG_TWO);
  wire wr_lock = reg_wr_i && (reg_addr_i == ADDR_LOCK_CFG);
  wire [23:0] status_word = 24'(locked_r) << STATUS_LOCK_POS;

  // Read mux; unmapped indices read as zero, pad bits as zero
  always_comb begin
    case (reg_addr_i)
      ADDR_AUX_CFG_ONE: rdata_nxt = {1'b0, cfg_one_r[22:0]};
      ADDR_AUX_CFG_TWO: rdata_nxt = {19'h0, cfg_two_r[4:0]};
      ADDR_LOCK_CFG: rdata_nxt = {4'h0, lock_cfg_r[19:0]};
      ADDR_STATUS: rdata_nxt = status_word;
      default: rdata_nxt = 24'h000000;
    endcase
  end

  // Defaults at reset, hold until rewritten
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cfg_one_r <= AUX_CFG_ONE_RST;
      cfg_two_r <= AUX_CFG_TWO_RST;
      lock_cfg_r <= LOCK_CFG_RST;
      reg_rdata_o <= 24'h000000;
    end else begin
      if (wr_one) cfg_one_r <= reg_wdata_i;
      if (wr_two) cfg_two_r <= reg_wdata_i;
      if (wr_lock) lock_cfg_r <= reg_wdata_i;
      if (reg_rd_i) reg_rdata_o <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ring oscillator, modelled as a divided core clock
  logic [15:0] ring_cnt_r;
  logic ring_r;
  wire ring_needed = (cfg_one_r.src_sel == SRC_RING) || cfg_one_r.form_mode[1]
    || lock_cfg_r.ring_window_sel || lock_cfg_r.ring_test || cfg_two_r.lfsr_from_ring;
  wire [15:0] ring_half = 16'(RING_HALF_BASE) << lock_cfg_r.ring_speed;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ring_cnt_r <= 16'h0000;
      ring_r <= 1'b0;
    end else if (!ring_needed) begin
      ring_cnt_r <= 16'h0000;
      ring_r <= 1'b0;
    end else if (ring_cnt_r + 16'h0001 >= ring_half) begin
      ring_cnt_r <= 16'h0000;
      ring_r <= ~ring_r;
    end else begin
      ring_cnt_r <= ring_cnt_r + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source select, clock forming and divider
  logic [DELAY_TAPS-1:0] dly_line_r;
  logic formed_prev_r;
  logic [6:0] div_cnt_r;
  logic aux_nxt;
  logic formed;

  wire src_clk = (cfg_one_r.src_sel == SRC_VCO_DIV) ? vco_div_clk_i :
                 (cfg_one_r.src_sel == SRC_XREF) ? xref_clk_i :
                 (cfg_one_r.src_sel == SRC_REF_DIV) ? ref_div_clk_i : ring_r;
  wire [2:0] dly_sel;
  wire delayed_clk = dly_line_r[dly_sel];

  // Forming mode selection
  always_comb begin
    case (cfg_one_r.form_mode)
      FORM_BYPASS: formed = src_clk;
      FORM_DELAY: formed = delayed_clk;
      FORM_RING: formed = ring_r;
      FORM_RING_GATED: formed = ring_r & src_clk;
      default: formed = src_clk;
    endcase
  end

  // Divide by two to the power of the select; select zero passes straight
  always_comb begin
    if (cfg_one_r.div_sel == 3'h0) aux_nxt = formed;
    else aux_nxt = div_cnt_r[cfg_one_r.div_sel - 3'h1];
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      dly_line_r <= '0;
      formed_prev_r <= 1'b0;
      div_cnt_r <= 7'h00;
      aux_clk_o <= 1'b0;
      dsm_ref_clk_o <= 1'b0;
    end else begin
      dly_line_r <= {dly_line_r[DELAY_TAPS-2:0], src_clk};
      formed_prev_r <= formed;
      if (rise(formed, formed_prev_r)) div_cnt_r <= div_cnt_r + 7'h01;
      aux_clk_o <= aux_nxt;
      dsm_ref_clk_o <= cfg_one_r.aux_to_dsm ? aux_nxt : natural_ref_clk_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Delay modulator: LFSR, accumulator and delay value
  logic [9:0] lfsr_r;
  logic [7:0] acc_r;
  logic square_r;
  logic mod_prev_r;
  logic lfsr_clk_prev_r;
  logic [2:0] dly_nxt;

  wire mod_clk = aux_clk_o ^ cfg_two_r.clk_invert;
  wire mod_tick = rise(mod_clk, mod_prev_r);
  wire lfsr_clk = cfg_two_r.lfsr_from_ring ? ring_r : mod_clk;
  wire lfsr_tick = rise(lfsr_clk, lfsr_clk_prev_r);
  wire [8:0] acc_sum = {1'b0, acc_r} + {1'b0, cfg_one_r.frac_step};

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      lfsr_r <= LFSR_SEED;
      acc_r <= 8'h00;
      square_r <= 1'b0;
      mod_prev_r <= 1'b0;
      lfsr_clk_prev_r <= 1'b0;
    end else begin
      mod_prev_r <= mod_clk;
      lfsr_clk_prev_r <= lfsr_clk;
      // Taps 10 and 7 give a maximal sequence
      if (cfg_one_r.lfsr_en && lfsr_tick) lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
      if (cfg_one_r.accum_en && mod_tick) begin
        acc_r <= acc_sum[7:0];
        if (acc_sum[8]) square_r <= ~square_r;
      end
    end
  end

  // Low amplitude flips bit 0 of the low value; high spans all settings
  always_comb begin
    case (cfg_one_r.dmod_mode)
      DMOD_PASS: dly_nxt = cfg_one_r.low_delay;
      DMOD_SQUARE: dly_nxt = square_r ? cfg_two_r.high_delay : cfg_one_r.low_delay;
      DMOD_LFSR_LO: dly_nxt = cfg_one_r.low_delay ^ {2'b00, lfsr_r[0]};
      DMOD_LFSR_HI: dly_nxt = lfsr_r[2:0];
      default: dly_nxt = cfg_one_r.low_delay;
    endcase
  end
  assign dly_sel = delay_setting_o;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) delay_setting_o <= 3'h0;
    else delay_setting_o <= dly_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock detector: one-shot window counting reference edges
  win_state_type win_state_r;
  logic [19:0] win_cnt_r;
  logic [10:0] ref_cnt_r;
  logic ref_prev_r;
  logic ring_prev_r;
  logic analog_prev_r;

  wire ref_tick = rise(ref_clk_i, ref_prev_r);
  wire ring_tick = rise(ring_r, ring_prev_r);
  wire analog_fall = ~analog_window_i & analog_prev_r;
  wire [19:0] win_base = 20'(WIN_BASE) << lock_cfg_r.win_duration;
  wire [19:0] asym_adj = 20'(ASYM_WIN_CYC);
  wire [19:0] win_len = !lock_cfg_r.asym_en ? win_base :
                        lock_cfg_r.asym_up ? win_base + asym_adj : win_base - asym_adj;
  // Ring window counts ring edges; the analog one-shot ends on its own falling edge
  wire win_step = lock_cfg_r.ring_window_sel ? ring_tick : 1'b1;
  wire win_done = (win_state_r == WIN_OPEN) && (lock_cfg_r.ring_window_sel ?
                  (win_cnt_r >= win_len) : analog_fall);
  wire [10:0] ref_cnt_nxt = ref_cnt_r + {10'h000, ref_tick};
  wire lock_hit = ref_cnt_nxt >= {1'b0, lock_cfg_r.lock_threshold};

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      win_state_r <= WIN_IDLE;
      win_cnt_r <= 20'h00000;
      ref_cnt_r <= 11'h000;
      ref_prev_r <= 1'b0;
      ring_prev_r <= 1'b0;
      analog_prev_r <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_clk_i;
      ring_prev_r <= ring_r;
      analog_prev_r <= analog_window_i;
      case (win_state_r)
        WIN_IDLE: begin
          if (ref_tick) begin
            win_state_r <= WIN_OPEN;
            win_cnt_r <= 20'h00000;
            ref_cnt_r <= 11'h000;
          end
        end
        WIN_OPEN: begin
          if (win_done) begin
            win_state_r <= WIN_IDLE;
            locked_r <= lock_hit;
          end else begin
            if (win_step) win_cnt_r <= win_cnt_r + 20'h00001;
            if (!ref_cnt_r[10]) ref_cnt_r <= ref_cnt_nxt;
          end
        end
        default: win_state_r <= WIN_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pins; forced mode wins over read data
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      serial_data_o <= 1'b0;
      ring_osc_o <= 1'b0;
      lock_window_o <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      if (lock_cfg_r.lock_to_serial_out_forced) serial_data_o <= locked_r;
      else if (sdo_read_active_i) serial_data_o <= sdo_read_data_i;
      else serial_data_o <= lock_cfg_r.lock_to_serial_out_auto & locked_r;
      ring_osc_o <= ring_r;
      lock_window_o <= (win_state_r == WIN_OPEN);
      locked_o <= locked_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_DIV_RESET: assert property ($rose(reset_n_i) |-> cfg_one_r.div_sel == 3'h2
    && cfg_one_r.aux_to_dsm) else $error("aux config reset value wrong");
  AST_CFG_HOLD: assert property (!wr_one && !wr_two |=> $stable(cfg_one_r)
    && $stable(cfg_two_r)) else $error("aux config changed without write");
  AST_DSM_REF: assert property (!cfg_one_r.aux_to_dsm && !wr_one
    |=> dsm_ref_clk_o == $past(natural_ref_clk_i)) else $error("modulator ref not natural");
  AST_LFSR_OFF: assert property (!cfg_one_r.lfsr_en |=> $stable(lfsr_r))
    else $error("lfsr moved while disabled");
  AST_ACC_OFF: assert property (!cfg_one_r.accum_en |=> $stable(acc_r)
    && $stable(square_r)) else $error("accumulator moved while disabled");
  AST_SQUARE_WRAP: assert property (cfg_one_r.accum_en && mod_tick && acc_sum[8]
    |=> square_r != $past(square_r)) else $error("square wave missed a wrap");
  AST_DELAY_PASS: assert property (cfg_one_r.dmod_mode == DMOD_PASS && !wr_one
    |=> delay_setting_o == $past(cfg_one_r.low_delay)) else $error("low delay not passed");
  AST_LOCK_DECIDE: assert property (win_done |=> locked_r == $past(lock_hit)
    ##1 locked_o == $past(locked_r)) else $error("lock decision wrong");
  AST_FORCED_OUT: assert property (lock_cfg_r.lock_to_serial_out_forced
    |=> serial_data_o == $past(locked_r)) else $error("forced lock not on serial out");
  AST_AUTO_OUT: assert property (!lock_cfg_r.lock_to_serial_out_forced && !sdo_read_active_i
    |=> serial_data_o == $past(lock_cfg_r.lock_to_serial_out_auto && locked_r))
    else $error("auto lock mux wrong");
  AST_STATUS_READ: assert property (reg_rd_i && reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o == {23'h0, $past(locked_r)}) else $error("status read wrong");

  COV_LOCK: cover property ($rose(locked_r));
  COV_FORCED: cover property (lock_cfg_r.lock_to_serial_out_forced && locked_r);
  COV_SQUARE: cover property (cfg_one_r.dmod_mode == DMOD_SQUARE && $changed(square_r));
  COV_RING_WIN: cover property (lock_cfg_r.ring_window_sel && win_done);

endmodule

/* File: aux_clock_pkg.sv */
// Package: register map, field layouts, reset values and timing for the aux clock block
package aux_clock_pkg;

  // Register indices on the main serial port
  localparam logic [5:0] ADDR_AUX_CFG_ONE = 6'h18;
  localparam logic [5:0] ADDR_AUX_CFG_TWO = 6'h19;
  localparam logic [5:0] ADDR_LOCK_CFG = 6'h1a;
  localparam logic [5:0] ADDR_STATUS = 6'h1f;

  // Reset values
  localparam logic [23:0] AUX_CFG_ONE_RST = 24'h0000a0;
  localparam logic [23:0] AUX_CFG_TWO_RST = 24'h00000f;
  localparam logic [23:0] LOCK_CFG_RST = 24'h001040;

  // Status register: locked flag in bit 0
  localparam int STATUS_LOCK_POS = 0;

  // Source selector codes
  localparam logic [1:0] SRC_VCO_DIV = 2'h0;
  localparam logic [1:0] SRC_XREF = 2'h1;
  localparam logic [1:0] SRC_REF_DIV = 2'h2;
  localparam logic [1:0] SRC_RING = 2'h3;

  // Clock forming modes
  localparam logic [1:0] FORM_BYPASS = 2'h0;
  localparam logic [1:0] FORM_DELAY = 2'h1;
  localparam logic [1:0] FORM_RING = 2'h2;
  localparam logic [1:0] FORM_RING_GATED = 2'h3;

  // Delay modulation modes
  localparam logic [1:0] DMOD_PASS = 2'h0;
  localparam logic [1:0] DMOD_SQUARE = 2'h1;
  localparam logic [1:0] DMOD_LFSR_LO = 2'h2;
  localparam logic [1:0] DMOD_LFSR_HI = 2'h3;

  // Timing: asymmetric window offset, nominal 10 ns, at 25 ns per cycle
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ASYM_WIN_PS = 10000;
  localparam int ASYM_WIN_CYC_RAW = (ASYM_WIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] ASYM_WIN_CYC = 16'(ASYM_WIN_CYC_RAW < 1 ? 1 : ASYM_WIN_CYC_RAW);

  // Seed loaded into the LFSR at reset, never all zero
  localparam logic [9:0] LFSR_SEED = 10'h001;

  typedef struct packed {
    logic pad;
    logic [2:0] low_delay;
    logic [7:0] frac_step;
    logic [1:0] dmod_mode;
    logic accum_en;
    logic lfsr_en;
    logic aux_to_dsm;
    logic [2:0] div_sel;
    logic [1:0] form_mode;
    logic [1:0] src_sel;
  } aux_cfg_one_type;

  typedef struct packed {
    logic [18:0] pad;
    logic lfsr_from_ring;
    logic clk_invert;
    logic [2:0] high_delay;
  } aux_cfg_two_type;

  typedef struct packed {
    logic [3:0] pad;
    logic ring_test;
    logic [1:0] win_duration;
    logic [1:0] ring_speed;
    logic ring_window_sel;
    logic lock_to_serial_out_forced;
    logic lock_to_serial_out_auto;
    logic asym_up;
    logic asym_en;
    logic [9:0] lock_threshold;
  } lock_cfg_type;

  typedef enum logic [0:0] {
    WIN_IDLE = 1'b0,
    WIN_OPEN = 1'b1
  } win_state_type;

endpackage

/* File: clk_source_model.sv */
// Far-side model: synthesizer clock sources and the analog lock-detect one-shot
`timescale 1ns/1ps
module clk_source_model #(
  parameter int VCO_HALF = 2,
  parameter int XREF_HALF = 3,
  parameter int REFDIV_HALF = 4,
  parameter int REF_HALF = 2
) (
  input wire logic core_clk_i,
  input wire logic win_go_i,
  input wire logic [7:0] win_len_i,
  output logic vco_div_clk_o,
  output logic xref_clk_o,
  output logic ref_div_clk_o,
  output logic ref_clk_o,
  output logic analog_window_o
);
  int n = 0;
  int w = 0;
  ////////////////////////////////////////
  // Free-running sources, moved on the falling edge so the block samples settled levels
  always @(negedge core_clk_i) begin
    n <= n + 1;
  end
  assign vco_div_clk_o = ((n / VCO_HALF) % 2) == 1;
  assign xref_clk_o = ((n / XREF_HALF) % 2) == 1;
  assign ref_div_clk_o = ((n / REFDIV_HALF) % 2) == 1;
  assign ref_clk_o = ((n / REF_HALF) % 2) == 1;
  // One-shot: high for the asked length, its fall ends the window
  always @(negedge core_clk_i) begin
    if (win_go_i) begin
      w <= win_len_i;
    end else if (w > 0) begin
      w <= w - 1;
    end
  end
  assign analog_window_o = w != 0;
endmodule

/* File: aux_clock_and_lock_detect_tb.sv */
// Self-checking bench for the aux clock and lock detector block
`timescale 1ns/1ps
module aux_clock_and_lock_detect_tb;
  import aux_clock_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [23:0] reg_wdata_i = 24'h000000;
  logic [23:0] reg_rdata_o;
  logic vco, xref, refdiv, refclk, awin;
  logic natural_ref = 1'b0;
  logic rd_active = 1'b0;
  logic rd_data = 1'b0;
  logic win_go = 1'b0;
  logic serial_data_o, aux_clk_o, dsm_ref_clk_o, ring_osc_o, lock_window_o, locked_o;
  logic [2:0] delay_setting_o;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ta, td, tr;
  int hist [8];
  aux_cfg_one_type c1;
  logic [23:0] d;
  clk_source_model clk_source_model_i (.core_clk_i(core_clk_i), .win_go_i(win_go),
    .win_len_i(8'h28), .vco_div_clk_o(vco), .xref_clk_o(xref), .ref_div_clk_o(refdiv),
    .ref_clk_o(refclk), .analog_window_o(awin));
  // Short window base keeps ring-timed windows brief
  aux_clock_and_lock_detect #(.WIN_BASE(8)) aux_clock_and_lock_detect_i (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .vco_div_clk_i(vco), .xref_clk_i(xref),
    .ref_div_clk_i(refdiv), .natural_ref_clk_i(natural_ref), .ref_clk_i(refclk),
    .analog_window_i(awin), .sdo_read_active_i(rd_active), .sdo_read_data_i(rd_data),
    .serial_data_o(serial_data_o), .aux_clk_o(aux_clk_o), .dsm_ref_clk_o(dsm_ref_clk_o),
    .delay_setting_o(delay_setting_o), .ring_osc_o(ring_osc_o),
    .lock_window_o(lock_window_o), .locked_o(locked_o));
  ////////////////////////////////////////
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic near(input int seen, input int e, input int tol);
    chk(32'(seen >= e - tol && seen <= e + tol), 32'h1);
  endtask
  ////////////////////////////////////////
  // Register port: one-cycle strobes, data sampled after the read edge
  task automatic wr(input logic [5:0] a, input logic [23:0] v);
    @(negedge core_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge core_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  // Counts toggles and delay values over n cycles
  task automatic watch(input int n);
    logic pa, pd, pr;
    ta = 0;
    td = 0;
    tr = 0;
    foreach (hist[i]) hist[i] = 0;
    @(negedge core_clk_i);
    pa = aux_clk_o;
    pd = dsm_ref_clk_o;
    pr = ring_osc_o;
    repeat (n) begin
      @(negedge core_clk_i);
      ta += int'(aux_clk_o !== pa);
      td += int'(dsm_ref_clk_o !== pd);
      tr += int'(ring_osc_o !== pr);
      pa = aux_clk_o;
      pd = dsm_ref_clk_o;
      pr = ring_osc_o;
      hist[delay_setting_o]++;
    end
  endtask
  // Number of distinct delay settings seen by the last watch
  function automatic int spread();
    spread = 0;
    foreach (hist[i]) spread += int'(hist[i] > 0);
  endfunction
  // Cycles of one whole window opened after the last config write
  task automatic win_len_of(output int len);
    len = 0;
    @(negedge core_clk_i);
    while (lock_window_o !== 1'b0) @(negedge core_clk_i);
    while (lock_window_o !== 1'b1) @(negedge core_clk_i);
    while (lock_window_o === 1'b1) begin
      len++;
      @(negedge core_clk_i);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rd(ADDR_AUX_CFG_ONE); chk(d, AUX_CFG_ONE_RST);
    rd(ADDR_AUX_CFG_TWO); chk(d, AUX_CFG_TWO_RST);
    rd(ADDR_LOCK_CFG); chk(d, LOCK_CFG_RST);
    rd(ADDR_STATUS); chk(d, 24'h000000);
    rd(6'h00); chk(d, 24'h000000);
  endtask
  // Pad bits read zero; forced bit kept clear since reads follow
  task automatic t_regs();
    wr(ADDR_AUX_CFG_ONE, 24'hffffff); rd(ADDR_AUX_CFG_ONE); chk(d, 24'h7fffff);
    wr(ADDR_AUX_CFG_TWO, 24'hffffff); rd(ADDR_AUX_CFG_TWO); chk(d, 24'h00001f);
    wr(ADDR_LOCK_CFG, 24'hffdfff); rd(ADDR_LOCK_CFG); chk(d, 24'h0fdfff);
    wr(6'h00, 24'hffffff); rd(6'h00); chk(d, 24'h000000);
    wr(ADDR_STATUS, 24'hffffff); rd(ADDR_STATUS); chk(d, 24'h000000);
    wr(ADDR_AUX_CFG_ONE, AUX_CFG_ONE_RST);
    wr(ADDR_AUX_CFG_TWO, AUX_CFG_TWO_RST);
    wr(ADDR_LOCK_CFG, LOCK_CFG_RST);
  endtask
  task automatic pulse_window();
    @(negedge core_clk_i);
    win_go = 1'b1;
    @(negedge core_clk_i);
    win_go = 1'b0;
    repeat (60) @(negedge core_clk_i);
  endtask
  // Lock on a 40-cycle analog window, then the serial-out mux
  task automatic t_lock();
    wr(ADDR_LOCK_CFG, 24'h001003);
    pulse_window();
    rd(ADDR_STATUS); chk(d, 24'h000001);
    chk(locked_o, 1'b1);
    chk(serial_data_o, 1'b1);
    rd_active = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk(serial_data_o, 1'b0);
    rd_data = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk(serial_data_o, 1'b1);
    rd_data = 1'b0;
    // Read data is driven here only to show forced mode ignores it
    wr(ADDR_LOCK_CFG, 24'h003003);
    repeat (2) @(negedge core_clk_i);
    chk(serial_data_o, 1'b1);
    wr(ADDR_LOCK_CFG, 24'h0033ff);
    rd_data = 1'b1;
    pulse_window();
    chk(locked_o, 1'b0);
    chk(serial_data_o, 1'b0);
    rd_active = 1'b0;
    rd_data = 1'b0;
    wr(ADDR_LOCK_CFG, LOCK_CFG_RST);
  endtask
  ////////////////////////////////////////
  task automatic t_src();
    int fast;
    c1 = AUX_CFG_ONE_RST;
    c1.div_sel = 3'h0;
    for (int s = 0; s < 3; s++) begin
      c1.src_sel = 2'(s);
      wr(ADDR_AUX_CFG_ONE, c1);
      watch(64);
      near(ta, 64 / (s + 2), 2);
      near(td, ta, 2);
    end
    c1.src_sel = SRC_VCO_DIV;
    for (int n = 1; n < 4; n++) begin
      c1.div_sel = 3'(n);
      wr(ADDR_AUX_CFG_ONE, c1);
      watch(64);
      near(ta, 32 >> n, 2);
    end
    c1.div_sel = 3'h0;
    c1.aux_to_dsm = 1'b0;
    c1.form_mode = FORM_DELAY;
    c1.low_delay = 3'h3;
    wr(ADDR_AUX_CFG_ONE, c1);
    watch(64);
    near(ta, 32, 2);
    chk(td, 0);
    // Ring runs alone in test mode; compare fastest with slowest
    wr(ADDR_LOCK_CFG, 24'h081040);
    watch(128);
    chk(32'(tr > 0), 32'h1);
    fast = tr;
    wr(ADDR_LOCK_CFG, 24'h099040);
    watch(128);
    chk(32'(fast > tr), 32'h1);
    c1.src_sel = SRC_RING;
    for (int f = 0; f < 4; f++) begin
      c1.form_mode = 2'(f);
      wr(ADDR_AUX_CFG_ONE, c1);
      watch(128);
      chk(32'(ta > 0), 32'h1);
    end
    wr(ADDR_LOCK_CFG, LOCK_CFG_RST);
  endtask
  task automatic t_delay();
    int k;
    c1 = AUX_CFG_ONE_RST;
    c1.div_sel = 3'h0;
    c1.low_delay = 3'h5;
    wr(ADDR_AUX_CFG_ONE, c1);
    watch(32);
    chk(hist[5], 32);
    c1.dmod_mode = DMOD_SQUARE;
    c1.accum_en = 1'b1;
    c1.frac_step = 8'h80;
    c1.low_delay = 3'h2;
    wr(ADDR_AUX_CFG_ONE, c1);
    watch(128);
    chk(hist[2] + hist[7], 128);
    chk(32'(hist[2] > 0 && hist[7] > 0), 32'h1);
    c1.dmod_mode = DMOD_LFSR_HI;
    c1.lfsr_en = 1'b1;
    wr(ADDR_AUX_CFG_ONE, c1);
    watch(256);
    k = 0;
    foreach (hist[i]) k += int'(hist[i] > 0);
    chk(32'(k > 3), 32'h1);
    c1.dmod_mode = DMOD_LFSR_LO;
    c1.low_delay = 3'h4;
    wr(ADDR_AUX_CFG_ONE, c1);
    watch(256);
    chk(hist[4] + hist[5], 256);
    // Slow aux clock barely steps the LFSR; the ring clock steps it often
    c1.dmod_mode = DMOD_LFSR_HI;
    c1.div_sel = 3'h7;
    wr(ADDR_AUX_CFG_ONE, c1);
    watch(64);
    chk(32'(spread() <= 2), 32'h1);
    wr(ADDR_AUX_CFG_TWO, AUX_CFG_TWO_RST | 24'h000010);
    watch(256);
    chk(32'(spread() > 3), 32'h1);
    wr(ADDR_AUX_CFG_TWO, AUX_CFG_TWO_RST);
  endtask
  // Ring-timed window: base 8 ring ticks, ring period 4 cycles at fastest speed
  task automatic t_window();
    int w0, w1, wup, wdn;
    wr(ADDR_LOCK_CFG, 24'h005040);
    win_len_of(w0);
    chk(32'(w0 > 0), 32'h1);
    wr(ADDR_LOCK_CFG, 24'h025040);
    win_len_of(w1);
    chk(w1 - w0, 32);
    wr(ADDR_LOCK_CFG, 24'h005c40);
    win_len_of(wup);
    chk(wup - w0, 4);
    wr(ADDR_LOCK_CFG, 24'h005440);
    win_len_of(wdn);
    chk(w0 - wdn, 4);
    wr(ADDR_LOCK_CFG, LOCK_CFG_RST);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_regs();
    t_lock();
    t_src();
    t_delay();
    t_window();
    print_verdict();
  end
endmodule
